// ---- design/sas_pkg.sv ----
// shared constants and types of the converter sequencer
`default_nettype none
package sas_pkg;

  // ***********************************************************
  // register map (byte addresses)
  // ***********************************************************
  localparam logic [7:0] CTRL1_OFS    = 8'h00;
  localparam logic [7:0] CTRL2_OFS    = 8'h04;
  localparam logic [7:0] CTRL4_OFS    = 8'h08;
  localparam logic [7:0] INSEL_OFS    = 8'h0C;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] BUF_BASE_OFS = 8'h40;
  localparam int         BUF_WORDS    = 16;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int C1_ON     = 15;
  localparam int C1_SIDL   = 13;
  localparam int C1_BMODE  = 12;
  localparam int C1_RES12  = 10;
  localparam int C1_FMT    = 8;
  localparam int C1_SRC    = 5;
  localparam int C1_GRP    = 4;
  localparam int C1_SIM    = 3;
  localparam int C1_AUTO_SAMPLE_START   = 2;
  localparam int C1_SAMPLE_ACTIVE   = 1;
  localparam int C1_DONE   = 0;
  localparam int C2_SCAN   = 10;
  localparam int C2_CHANNEL_COUNT_SELECT   = 8;
  localparam int C2_SAMPLE_COUNT   = 2;
  localparam int C4_DMAEN  = 8;
  localparam logic [5:0] UPPER_INPUT_FIRST = 6'h20;

  // ***********************************************************
  // encodings and reset values
  // ***********************************************************
  localparam logic [2:0] SRC_MANUAL = 3'h0;
  localparam logic [2:0] SRC_AUTO   = 3'h7;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS    = 5;
  localparam int SAMPLE_TIME_NS   = 100;
  localparam int CONV10_TIME_NS   = 600;
  localparam int CONV12_TIME_NS   = 1400;
  localparam int SAMPLE_CYCLES =
    (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV10_CYCLES =
    (CONV10_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV12_CYCLES =
    (CONV12_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SAS_IDLE    = 2'b00,
    SAS_SAMPLE  = 2'b01,
    SAS_CONVERT = 2'b11
  } sas_state_t;

endpackage : sas_pkg
`default_nettype wire

// ---- design/sas_format.sv ----
// result layout: integer, signed integer, fractional, signed fractional
`default_nettype none
module sas_format (
  // conversion input
  input  wire logic [11:0] raw,
  input  wire logic        res12,
  input  wire logic [1:0]  fmt,
  // formatted result
  output logic      [15:0] dout
);
  import sas_pkg::*;

  always_comb begin
    if (res12) begin
      case (fmt)
        2'h0:    dout = {4'h0, raw};
        2'h1:    dout = {{5{~raw[11]}}, raw[10:0]};
        2'h2:    dout = {raw, 4'h0};
        2'h3:    dout = {~raw[11], raw[10:0], 4'h0};
        default: dout = 16'h0000;
      endcase
    end else begin
      case (fmt)
        2'h0:    dout = {6'h00, raw[9:0]};
        2'h1:    dout = {{7{~raw[9]}}, raw[8:0]};
        2'h2:    dout = {raw[9:0], 6'h00};
        2'h3:    dout = {~raw[9], raw[8:0], 6'h00};
        default: dout = 16'h0000;
      endcase
    end
  end

endmodule : sas_format
`default_nettype wire

// ---- design/sas_trigger.sv ----
// selects the hardware trigger that ends sampling
`default_nettype none
module sas_trigger (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // selection
  input  wire logic       grp,
  input  wire logic [2:0] src,
  // on-chip pulses
  input  wire logic [2:0] pwm_gen_trig,
  input  wire logic [3:0] seq_trig,
  input  wire logic       tmu_trig,
  input  wire logic       pwm_sec_trig,
  input  wire logic       timer5_trig,
  input  wire logic       pwm_pri_trig,
  input  wire logic       timer3_trig,
  // pin
  input  wire logic       ext_int_pin,
  // selected pulse
  output logic            hw_trig
);
  import sas_pkg::*;

  logic pin_meta;
  logic pin_sync;
  logic pin_last;

  // ***********************************************************
  // pin synchroniser and edge detect
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= ext_int_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  always_comb begin
    if (grp) begin
      case (src)
        3'h0, 3'h1, 3'h2: hw_trig = pwm_gen_trig[src[1:0]];
        3'h3:    hw_trig = seq_trig[0];
        3'h4:    hw_trig = seq_trig[1];
        3'h5:    hw_trig = seq_trig[2];
        3'h6:    hw_trig = seq_trig[3];
        default: hw_trig = 1'b0;
      endcase
    end else begin
      case (src)
        3'h6:    hw_trig = tmu_trig;
        3'h5:    hw_trig = pwm_sec_trig;
        3'h4:    hw_trig = timer5_trig;
        3'h3:    hw_trig = pwm_pri_trig;
        3'h2:    hw_trig = timer3_trig;
        3'h1:    hw_trig = pin_sync & ~pin_last;
        default: hw_trig = 1'b0;
      endcase
    end
  end

endmodule : sas_trigger
`default_nettype wire

// ---- design/sas_sequencer.sv ----
// sample/convert sequencer of a successive-approximation converter
//
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
module sas_sequencer (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger sources
  input  wire logic [2:0]  pwm_gen_trig,
  input  wire logic [3:0]  seq_trig,
  input  wire logic        tmu_trig,
  input  wire logic        pwm_sec_trig,
  input  wire logic        timer5_trig,
  input  wire logic        pwm_pri_trig,
  input  wire logic        timer3_trig,
  input  wire logic        ext_int_pin,
  // power state
  input  wire logic        idle_mode,
  // analog core
  input  wire logic [11:0] analog_result,
  output logic      [3:0]  sh_sample,
  output logic      [1:0]  conv_channel,
  output logic             converting,
  output logic      [5:0]  input_select,
  output logic             input_valid,
  // events and dma
  output logic             adc_event,
  output logic             scan_restart,
  output logic             dma_request,
  output logic             dma_addr_step,
  output logic      [3:0]  dma_buf_index
);
  import sas_pkg::*;

  // ***********************************************************
  // declarations
  // ***********************************************************
  logic        conv_on, idle_stop, build_mode, res12, trig_grp;
  logic        simultaneous_sample_q, auto_sample_start, sample_active, done, scan_en, dma_en;
  logic [1:0]  out_fmt, channel_count_select_q;
  logic [2:0]  trig_src;
  logic [4:0]  sample_count;
  logic [5:0]  insel;
  logic [15:0] rbuf [BUF_WORDS];
  sas_state_t  state, next_state;
  logic [8:0]  tmr;
  logic [1:0]  chan;
  logic [4:0]  cnt;
  logic        hw_trig, run, wr, manual_end, end_sample;
  logic        res_evt, last_chan, wrap, simultaneous_sample, fin_last;
  logic [1:0]  channel_count_select;
  logic [15:0] fmt_res;
  logic [3:0]  wr_idx;
  logic [8:0]  conv_len;

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [1:0] last_of(input logic [1:0] c);
    last_of = c[1] ? 2'h3 : {1'b0, c[0]};
  endfunction : last_of

  function automatic logic [4:0] limit_of(input logic [4:0] s,
                                          input logic d);
    limit_of = d ? s : {1'b0, s[3:0]};
  endfunction : limit_of

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTRL1_OFS) || (a == CTRL2_OFS) ||
             (a == CTRL4_OFS) || (a == INSEL_OFS) ||
             (a == STATUS_OFS) ||
             (a >= BUF_BASE_OFS && a[1:0] == 2'h0 &&
              a < BUF_BASE_OFS + 8'(4 * BUF_WORDS));
  endfunction : mapped

  assign simultaneous_sample   = simultaneous_sample_q & ~res12;
  assign channel_count_select     = res12 ? 2'h0 : channel_count_select_q;
  assign wr       = psel & penable & pwrite;
  assign run      = conv_on & ~(idle_stop & idle_mode);
  assign conv_len = res12 ? 9'(CONV12_CYCLES) : 9'(CONV10_CYCLES);
  assign last_chan = (chan == last_of(channel_count_select));
  assign res_evt  = run && state == SAS_CONVERT && tmr == conv_len - 9'h1;
  assign fin_last = res_evt & last_chan;
  assign wrap     = res_evt && cnt == limit_of(sample_count, dma_en);
  assign wr_idx   = dma_en ? 4'h0 : cnt[3:0];

  // software write of zero to the sample bit under manual code
  assign manual_end = wr && paddr == CTRL1_OFS && !pwdata[C1_SAMPLE_ACTIVE] &&
                      !trig_grp && trig_src == SRC_MANUAL;
  assign end_sample = run && state == SAS_SAMPLE && sample_active &&
    (manual_end ||
     hw_trig ||
     (!trig_grp && trig_src == SRC_AUTO &&
      tmr == 9'(SAMPLE_CYCLES - 1)));

  sas_trigger u_trig (
    .pclk         (pclk),
    .presetn      (presetn),
    .grp          (trig_grp),
    .src          (trig_src),
    .pwm_gen_trig (pwm_gen_trig),
    .seq_trig     (seq_trig),
    .tmu_trig     (tmu_trig),
    .pwm_sec_trig (pwm_sec_trig),
    .timer5_trig  (timer5_trig),
    .pwm_pri_trig (pwm_pri_trig),
    .timer3_trig  (timer3_trig),
    .ext_int_pin  (ext_int_pin),
    .hw_trig      (hw_trig)
  );

  sas_format u_fmt (
    .raw   (analog_result),
    .res12 (res12),
    .fmt   (out_fmt),
    .dout  (fmt_res)
  );

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {conv_on, idle_stop, build_mode, res12} <= 4'h0;
      {out_fmt, trig_src, trig_grp, simultaneous_sample_q, auto_sample_start} <= 8'h00;
      {scan_en, channel_count_select_q, sample_count, dma_en} <= 9'h000;
      insel <= 6'h00;
    end else if (wr) begin
      case (paddr)
        CTRL1_OFS: begin
          conv_on    <= pwdata[C1_ON];
          idle_stop  <= pwdata[C1_SIDL];
          build_mode <= pwdata[C1_BMODE];
          res12      <= pwdata[C1_RES12];
          out_fmt    <= pwdata[C1_FMT +: 2];
          trig_src   <= pwdata[C1_SRC +: 3];
          trig_grp   <= pwdata[C1_GRP];
          simultaneous_sample_q   <= pwdata[C1_SIM];
          auto_sample_start       <= pwdata[C1_AUTO_SAMPLE_START];
        end
        CTRL2_OFS: begin
          scan_en <= pwdata[C2_SCAN];
          channel_count_select_q  <= pwdata[C2_CHANNEL_COUNT_SELECT +: 2];
          sample_count    <= pwdata[C2_SAMPLE_COUNT +: 5];
        end
        CTRL4_OFS: dma_en <= pwdata[C4_DMAEN];
        INSEL_OFS: insel  <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // ***********************************************************
  // sample and completion flags
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_active <= 1'b0;
    end else if (end_sample) begin
      sample_active <= 1'b0;
    end else if (fin_last && auto_sample_start) begin
      sample_active <= 1'b1;
    end else if (wr && paddr == CTRL1_OFS && !pwdata[C1_AUTO_SAMPLE_START]) begin
      if (pwdata[C1_SAMPLE_ACTIVE]) begin
        sample_active <= 1'b1;
      end else if (state != SAS_SAMPLE || !run) begin
        sample_active <= 1'b0;
      end
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else if (fin_last) begin
      done <= 1'b1;
    end else if (end_sample) begin
      done <= 1'b0;
    end else if (wr && paddr == CTRL1_OFS && !pwdata[C1_DONE]) begin
      done <= 1'b0;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_comb begin
    next_state = state;
    case (state)
      SAS_IDLE:    if (sample_active) next_state = SAS_SAMPLE;
      SAS_SAMPLE:  if (end_sample) next_state = SAS_CONVERT;
      SAS_CONVERT: if (fin_last) next_state = SAS_IDLE;
      default:     next_state = SAS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SAS_IDLE;
    end else if (!conv_on) begin
      state <= SAS_IDLE;
    end else if (run) begin
      state <= next_state;
    end
  end

  // shared sample and conversion timer, channel index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr  <= 9'h000;
      chan <= 2'h0;
    end else if (!conv_on || (run && state == SAS_IDLE) ||
                 end_sample) begin
      tmr  <= 9'h000;
      chan <= 2'h0;
    end else if (res_evt) begin
      tmr  <= 9'h000;
      chan <= last_chan ? 2'h0 : chan + 2'h1;
    end else if (run && tmr != 9'h1FF) begin
      tmr  <= tmr + 9'h001;
    end
  end

  // ***********************************************************
  // result storage and conversion count
  // ***********************************************************
  always_ff @(posedge pclk) begin
    if (res_evt) begin
      rbuf[wr_idx] <= fmt_res;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 5'h00;
    end else if (!conv_on) begin
      cnt <= 5'h00;
    end else if (wrap) begin
      cnt <= 5'h00;
    end else if (res_evt) begin
      cnt <= cnt + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_event     <= 1'b0;
      scan_restart  <= 1'b0;
      dma_request   <= 1'b0;
      dma_addr_step <= 1'b0;
      dma_buf_index <= 4'h0;
    end else begin
      adc_event     <= dma_en ? res_evt : wrap;
      scan_restart  <= wrap & scan_en;
      dma_request   <= res_evt & dma_en;
      dma_addr_step <= wrap & dma_en;
      if (res_evt) begin
        dma_buf_index <= build_mode ? cnt[3:0] : {2'h0, chan};
      end
    end
  end

  // ***********************************************************
  // analog core control
  // ***********************************************************
  always_comb begin
    sh_sample = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (2'(i) <= last_of(channel_count_select)) begin
        if (state == SAS_SAMPLE) begin
          sh_sample[i] = 1'b1;
        end else if (state == SAS_CONVERT && !simultaneous_sample) begin
          sh_sample[i] = 2'(i) > chan;
        end
      end
    end
  end

  assign conv_channel = chan;
  assign converting   = (state == SAS_CONVERT);
  assign input_select = insel;
  assign input_valid  = !(res12 && insel >= UPPER_INPUT_FIRST);

  // ***********************************************************
  // apb read path
  // ***********************************************************
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
      case (paddr)
        CTRL1_OFS: prdata[15:0] <= {conv_on, 1'b0, idle_stop, build_mode,
          1'b0, res12, out_fmt, trig_src, trig_grp, simultaneous_sample,
          auto_sample_start, sample_active, done};
        CTRL2_OFS: prdata[15:0] <= {5'h00, scan_en, channel_count_select,
          1'b0, sample_count, 2'h0};
        CTRL4_OFS: prdata[C4_DMAEN] <= dma_en;
        INSEL_OFS: prdata[5:0] <= insel;
        STATUS_OFS: prdata[7:0] <= {1'b0, state, cnt};
        default: begin
          if (mapped(paddr)) begin
            prdata[15:0] <= rbuf[paddr[5:2]];
          end
        end
      endcase
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_done_on_finish: assert property (fin_last |=> done)
    else $error("completion flag not set after last conversion");
  a_done_on_start: assert property (end_sample |=> !done)
    else $error("completion flag not cleared at conversion start");
  a_sample_active_cleared: assert property (end_sample |=> !sample_active)
    else $error("sample bit not cleared by trigger");
  a_auto_restart: assert property (fin_last && auto_sample_start |=> sample_active ##1
    state == SAS_SAMPLE)
    else $error("auto-start did not restart sampling");
  a_simultaneous_sample_zero: assert property (res12 |-> !simultaneous_sample && channel_count_select == 2'h0)
    else $error("12-bit mode shows multichannel bits");
  a_dma_first: assert property (res_evt && dma_en |-> wr_idx == 4'h0)
    else $error("dma mode wrote past first buffer");
  a_ptr_wrap: assert property (wrap |=> cnt == 5'h00 ##1
    !wrap)
    else $error("conversion count did not wrap");
  a_event_rate: assert property (!dma_en && res_evt && !wrap |=>
    !adc_event)
    else $error("event raised before count reached");
  a_off_idle: assert property (!conv_on |=> state == SAS_IDLE)
    else $error("converter active while off");
  a_sim_hold: assert property (state == SAS_CONVERT && simultaneous_sample |->
    sh_sample == 4'h0)
    else $error("simultaneous channels not held together");
  a_upper_inputs: assert property (res12 && insel[5] |-> !input_valid)
    else $error("upper input usable in 12-bit mode");

  c_manual: cover property (manual_end && state == SAS_SAMPLE ##[1:400]
    fin_last);
  c_auto_wrap: cover property (auto_sample_start && wrap);
  c_dma_step: cover property (dma_addr_step);
  c_four_seq: cover property (res_evt && chan == 2'h3 && !simultaneous_sample);

endmodule : sas_sequencer
`default_nettype wire

// ---- sim/sas_far_model.sv ----
// far side model: trigger sources and analog core
`default_nettype none
module sas_far_model (
  // clock
  input  wire logic        pclk,
  // commands from the bench
  input  wire logic        fire,
  input  wire logic [3:0]  idx,
  input  wire logic [11:0] value,
  // converter side
  input  wire logic        converting,
  output logic      [15:0] trig,
  output logic      [11:0] analog_result
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle pulse on the chosen source, indexed {group, code}
  always_ff @(posedge pclk) begin
    trig <= fire ? (16'h0001 << idx) : 16'h0000;
  end
  // outside conversion the lines show no stale result
  always_comb begin
    analog_result = converting ? value : ~value;
  end
endmodule : sas_far_model
`default_nettype wire

// ---- sim/tb_sar_adc_sequencer.sv ----
// self-checking bench of the converter sequencer
`default_nettype none
module tb_sar_adc_sequencer import sas_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals
  // ************************************************************
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        fire    = 1'b0;
  logic [3:0]  idx     = 4'h0;
  logic [11:0] value   = 12'h000;
  logic        idle_mode = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, converting, adc_event;
  logic [15:0] trig;
  logic [11:0] analog_result;
  int          n_fail = 0, cmp_count = 0, cyc = 0, n_evt = 0;

  always #2.5 pclk = ~pclk;

  sas_sequencer dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_gen_trig(trig[10:8]),
    .seq_trig(trig[14:11]), .tmu_trig(trig[6]), .pwm_sec_trig(trig[5]),
    .timer5_trig(trig[4]), .pwm_pri_trig(trig[3]), .timer3_trig(trig[2]),
    .ext_int_pin(trig[1]), .idle_mode(idle_mode),
    .analog_result(analog_result), .sh_sample(), .conv_channel(),
    .converting(converting), .input_select(), .input_valid(),
    .adc_event(adc_event), .scan_restart(), .dma_request(),
    .dma_addr_step(), .dma_buf_index()
  );

  sas_far_model far (
    .pclk(pclk), .fire(fire), .idx(idx), .value(value),
    .converting(converting), .trig(trig), .analog_result(analog_result)
  );

  always @(posedge pclk) begin
    if (adc_event === 1'b1) n_evt++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // poll until done, then expect done set and sample bit clear
  task automatic wait_done;
    for (int n = 0; n < 200; n++) begin
      apb(1'b0, CTRL1_OFS, 32'h0);
      if (rd[C1_DONE] === 1'b1) break;
    end
    chk({30'h0, rd[1:0]}, 32'h1);
  endtask : wait_done
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs;
    apb(1'b0, CTRL1_OFS, 32'h0);
    chk(rd, {16'h0, REG_RESET});
    apb(1'b1, CTRL1_OFS, 32'h0000_0408);
    apb(1'b0, CTRL1_OFS, 32'h0);
    chk(rd, 32'h0000_0400);
    apb(1'b1, CTRL2_OFS, 32'h0000_0300);
    apb(1'b0, CTRL2_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, CTRL2_OFS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, CTRL1_OFS, 32'h0);
  endtask : t_regs

  task automatic t_manual;
    logic [31:0] cfg[2];
    logic [31:0] xp[2];
    cfg = '{32'h0000_8400, 32'h0000_8500};
    xp  = '{32'h0000_0A5C, 32'h0000_025C};
    value <= 12'hA5C;
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, CTRL1_OFS, cfg[f] | 32'h2);
      repeat (3) @(posedge pclk);
      apb(1'b1, CTRL1_OFS, cfg[f]);
      wait_done;
      apb(1'b0, BUF_BASE_OFS, 32'h0);
      chk(rd, xp[f]);
    end
    apb(1'b1, CTRL1_OFS, 32'h0);
  endtask : t_manual

  task automatic t_trig;
    value <= 12'h3C5;
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 8; c++) begin
        if ((g == 0 && c == 0) || (g == 1 && c == 7)) continue;
        apb(1'b1, CTRL1_OFS, 32'h8002 | (32'(c) << C1_SRC)
            | (32'(g) << C1_GRP));
        repeat (3) @(posedge pclk);
        fire <= 1'b1;
        idx  <= 4'(g * 8 + c);
        @(posedge pclk);
        fire <= 1'b0;
        wait_done;
        apb(1'b0, BUF_BASE_OFS, 32'h0);
        chk(rd, 32'h0000_03C5);
      end
    end
  endtask : t_trig

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_manual;
    t_trig;
    repeat (4) @(posedge pclk);
    chk(32'(n_evt), 32'd16);
    complete_run;
  end
endmodule : tb_sar_adc_sequencer
`default_nettype wire
